// ---- design/isl_i2c_slave_interface.sv ----
// two-wire serial slave interface with classic wishbone register access
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module isl_i2c_slave_interface
    import isl_pkg::*;
#(
    parameter int unsigned SERIAL_PINS = 1
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pin six: serial clock, open drain
    input  wire logic        port_a_bit_six_i,
    output logic             port_a_bit_six_o,
    output logic             port_a_bit_six_oe_o,
    // pin seven: serial data, open drain
    input  wire logic        port_a_bit_seven_i,
    output logic             port_a_bit_seven_o,
    output logic             port_a_bit_seven_oe_o,
    // general purpose use of the pins
    input  wire logic [1:0]  gpio_out_i,
    input  wire logic [1:0]  gpio_oe_i,
    output logic      [1:0]  gpio_in_o,
    // interrupt request towards the core
    input  wire logic        stack_not_full_i,
    output logic             irq_req_o,
    output logic      [7:0]  irq_vector_o
);

    if (SERIAL_PINS > 1)
    begin : g_check
        $error("SERIAL_PINS must be 0 or 1");
    end

    typedef struct packed {
        logic       scl_meta;
        logic       sda_meta;
        logic       scl_s;
        logic       sda_s;
        logic       scl_d;
        logic       sda_d;
        isl_state_e st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] own_addr;
        logic [7:0] data;
        logic       en;
        logic       tx;
        logic       noack;
        logic       done;
        logic       match;
        logic       busy;
        logic       dir;
        logic       nack;
        logic       irq_en;
        logic       irq_flag;
        logic       sda_low;
        logic       scl_low;
        logic       ack;
        logic [7:0] rdat;
    } isl_regs_s;

    isl_regs_s regs_ff;
    isl_regs_s nxt_regs;

    logic       serial_on;
    logic       scl_raw;
    logic       sda_raw;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       bus_req;
    logic       bus_wr;
    logic       bus_rd;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic       data_wr;
    logic       data_rd;

    function automatic logic reg_hit(input logic [31:0] adr, input logic [7:0] want);
        reg_hit = (adr[31:10] == 22'h000000) && (adr[9:2] == want);
    endfunction

    assign serial_on = (SERIAL_PINS == 1);
    assign scl_raw   = port_a_bit_six_i;
    assign sda_raw   = port_a_bit_seven_i;

    // edges come from the second and third stages only
    assign scl_rise   = regs_ff.scl_s & ~regs_ff.scl_d;
    assign scl_fall   = ~regs_ff.scl_s & regs_ff.scl_d;
    assign start_seen = serial_on & regs_ff.scl_s & regs_ff.scl_d & regs_ff.sda_d & ~regs_ff.sda_s;
    assign stop_seen  = serial_on & regs_ff.scl_s & regs_ff.scl_d & ~regs_ff.sda_d & regs_ff.sda_s;

    assign bus_req = wb_cyc_i & wb_stb_i & ~regs_ff.ack;
    assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    assign bus_rd  = bus_req & ~wb_we_i;
    assign idx     = wb_adr_i[9:2];
    assign wbyte   = wb_dat_i[7:0];
    assign data_wr = bus_wr & reg_hit(wb_adr_i, IDX_DATA);
    assign data_rd = bus_rd & reg_hit(wb_adr_i, IDX_DATA);

    always_comb
    begin
        nxt_regs = regs_ff;
        nxt_regs.scl_meta = scl_raw;
        nxt_regs.sda_meta = sda_raw;
        nxt_regs.scl_s    = regs_ff.scl_meta;
        nxt_regs.sda_s    = regs_ff.sda_meta;
        nxt_regs.scl_d    = regs_ff.scl_s;
        nxt_regs.sda_d    = regs_ff.sda_s;
        nxt_regs.ack      = bus_req;

        // software writes first so hardware sets in the same cycle win
        if (bus_wr && reg_hit(wb_adr_i, IDX_OWN_ADDR))
        begin
            nxt_regs.own_addr = {wbyte[7:ADDR_LSB_BIT], 1'b0};
        end
        if (bus_wr && reg_hit(wb_adr_i, IDX_CONTROL))
        begin
            nxt_regs.en    = wbyte[CTL_EN_BIT];
            nxt_regs.tx    = wbyte[CTL_TX_BIT];
            nxt_regs.noack = wbyte[CTL_NOACK_BIT];
            nxt_regs.match = 1'b0;
        end
        if (data_wr)
        begin
            nxt_regs.data = wbyte;
        end
        if (bus_wr && reg_hit(wb_adr_i, IDX_IRQ_CTRL))
        begin
            nxt_regs.irq_en = wbyte[IRQ_EN_BIT];
            // writing zero clears; writing one leaves it
            if (!wbyte[IRQ_FLAG_BIT])
            begin
                nxt_regs.irq_flag = 1'b0;
            end
        end

        // read data is captured with the ack
        nxt_regs.rdat = BYTE_ZERO;
        if (bus_rd)
        begin
            case (idx)
                IDX_OWN_ADDR: nxt_regs.rdat = regs_ff.own_addr;
                IDX_CONTROL:
                begin
                    nxt_regs.rdat[CTL_EN_BIT]    = regs_ff.en;
                    nxt_regs.rdat[CTL_TX_BIT]    = regs_ff.tx;
                    nxt_regs.rdat[CTL_NOACK_BIT] = regs_ff.noack;
                end
                IDX_STATUS:
                begin
                    nxt_regs.rdat[ST_DONE_BIT]  = regs_ff.done;
                    nxt_regs.rdat[ST_MATCH_BIT] = regs_ff.match;
                    nxt_regs.rdat[ST_BUSY_BIT]  = regs_ff.busy;
                    nxt_regs.rdat[ST_DIR_BIT]   = regs_ff.dir;
                    nxt_regs.rdat[ST_NACK_BIT]  = regs_ff.nack;
                end
                IDX_DATA:     nxt_regs.rdat = regs_ff.data;
                IDX_IRQ_CTRL:
                begin
                    nxt_regs.rdat[IRQ_EN_BIT]   = regs_ff.irq_en;
                    nxt_regs.rdat[IRQ_FLAG_BIT] = regs_ff.irq_flag;
                end
                default:      nxt_regs.rdat = BYTE_ZERO;
            endcase
            if (wb_adr_i[31:10] != 22'h000000)
            begin
                nxt_regs.rdat = BYTE_ZERO;
            end
        end

        if (start_seen)
        begin
            nxt_regs.busy = 1'b1;
        end
        else if (stop_seen)
        begin
            nxt_regs.busy = 1'b0;
        end

        if (!regs_ff.en)
        begin
            // disabled: let go of both lines
            nxt_regs.st      = ST_IDLE;
            nxt_regs.sda_low = 1'b0;
            nxt_regs.scl_low = 1'b0;
        end
        else if (start_seen)
        begin
            // repeated start also restarts address reception
            nxt_regs.st      = ST_ADDR;
            nxt_regs.cnt     = 4'h0;
            nxt_regs.sda_low = 1'b0;
            nxt_regs.scl_low = 1'b0;
        end
        else if (stop_seen)
        begin
            nxt_regs.st      = ST_IDLE;
            nxt_regs.sda_low = 1'b0;
            nxt_regs.scl_low = 1'b0;
        end
        else
        begin
            case (regs_ff.st)
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        nxt_regs.shift = {regs_ff.shift[6:0], regs_ff.sda_s};
                        nxt_regs.cnt   = regs_ff.cnt + CNT_ONE;
                    end
                    if (scl_fall && regs_ff.cnt == BITS_PER_BYTE)
                    begin
                        if (regs_ff.shift[7:1] == regs_ff.own_addr[7:ADDR_LSB_BIT])
                        begin
                            nxt_regs.match    = 1'b1;
                            nxt_regs.irq_flag = 1'b1;
                            nxt_regs.dir      = regs_ff.shift[0];
                            nxt_regs.sda_low  = 1'b1;
                            nxt_regs.st       = ST_ADDR_ACK;
                        end
                        else
                        begin
                            nxt_regs.match = 1'b0;
                            nxt_regs.st    = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_regs.sda_low = 1'b0;
                        nxt_regs.scl_low = 1'b1;
                        nxt_regs.st      = ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (data_wr || data_rd)
                    begin
                        nxt_regs.scl_low = 1'b0;
                        nxt_regs.cnt     = 4'h0;
                        nxt_regs.done    = 1'b0;
                        if (regs_ff.tx)
                        begin
                            nxt_regs.shift   = data_wr ? wbyte : regs_ff.data;
                            nxt_regs.sda_low = ~nxt_regs.shift[7];
                            nxt_regs.st      = ST_TX;
                        end
                        else
                        begin
                            // dummy read lets go of sda
                            nxt_regs.sda_low = 1'b0;
                            nxt_regs.st      = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        nxt_regs.cnt = regs_ff.cnt + CNT_ONE;
                        if (nxt_regs.cnt == BITS_PER_BYTE)
                        begin
                            nxt_regs.sda_low = 1'b0;
                            nxt_regs.st      = ST_TX_ACK;
                        end
                        else
                        begin
                            nxt_regs.shift   = {regs_ff.shift[6:0], 1'b0};
                            nxt_regs.sda_low = ~regs_ff.shift[6];
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        nxt_regs.nack = regs_ff.sda_s;
                    end
                    if (scl_fall)
                    begin
                        nxt_regs.done     = 1'b1;
                        nxt_regs.irq_flag = 1'b1;
                        nxt_regs.scl_low  = 1'b1;
                        nxt_regs.st       = ST_HOLD;
                    end
                end
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        nxt_regs.shift = {regs_ff.shift[6:0], regs_ff.sda_s};
                        nxt_regs.cnt   = regs_ff.cnt + CNT_ONE;
                    end
                    if (scl_fall && regs_ff.cnt == BITS_PER_BYTE)
                    begin
                        nxt_regs.data    = regs_ff.shift;
                        nxt_regs.sda_low = ~regs_ff.noack;
                        nxt_regs.st      = ST_RX_ACK;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_regs.sda_low  = 1'b0;
                        nxt_regs.done     = 1'b1;
                        nxt_regs.irq_flag = 1'b1;
                        nxt_regs.scl_low  = 1'b1;
                        nxt_regs.st       = ST_HOLD;
                    end
                end
                ST_IGNORE:
                begin
                    nxt_regs.sda_low = 1'b0;
                end
                default:
                begin
                    nxt_regs.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            regs_ff <= '0;
        end
        else
        begin
            regs_ff <= nxt_regs;
        end
    end

    assign wb_dat_o = {24'h000000, regs_ff.rdat};
    assign wb_ack_o = regs_ff.ack;

    // open drain: the pin only ever drives low in serial use
    assign port_a_bit_six_o      = serial_on ? 1'b0 : gpio_out_i[0];
    assign port_a_bit_six_oe_o   = serial_on ? regs_ff.scl_low : gpio_oe_i[0];
    assign port_a_bit_seven_o    = serial_on ? 1'b0 : gpio_out_i[1];
    assign port_a_bit_seven_oe_o = serial_on ? regs_ff.sda_low : gpio_oe_i[1];
    assign gpio_in_o             = {regs_ff.sda_s, regs_ff.scl_s};

    // enable gates the flag onto the request
    assign irq_req_o    = regs_ff.irq_flag & regs_ff.irq_en & stack_not_full_i;
    assign irq_vector_o = IRQ_VECTOR;

endmodule

`default_nettype wire

// ---- inc/isl_pkg.sv ----
// constants and types for the two-wire slave interface
package isl_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_OWN_ADDR  = 8'h20;
    localparam logic [7:0] IDX_CONTROL   = 8'h21;
    localparam logic [7:0] IDX_STATUS    = 8'h22;
    localparam logic [7:0] IDX_DATA      = 8'h23;
    localparam logic [7:0] IDX_IRQ_CTRL  = 8'h24;

    // control register fields
    localparam int CTL_EN_BIT    = 7;
    localparam int CTL_TX_BIT    = 4;
    localparam int CTL_NOACK_BIT = 3;

    // status register fields
    localparam int ST_DONE_BIT  = 7;
    localparam int ST_MATCH_BIT = 6;
    localparam int ST_BUSY_BIT  = 5;
    localparam int ST_DIR_BIT   = 2;
    localparam int ST_NACK_BIT  = 0;

    // interrupt control fields
    localparam int IRQ_EN_BIT   = 0;
    localparam int IRQ_FLAG_BIT = 1;

    // own address field: bits 7..1, bit 0 unused
    localparam int ADDR_LSB_BIT = 1;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [7:0] IRQ_VECTOR    = 8'h10;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_TX,
        ST_TX_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_IGNORE
    } isl_state_e;

endpackage

// ---- testbench/isl_master_model.sv ----
// behavioural two-wire bus master for the serial pins
`timescale 1ns/1ps
`default_nettype none
module isl_master_model (
    // wired line levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // high pulls the line low
    output logic      scl_low_o,
    output logic      sda_low_o
);
    localparam int QTR = 80;
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // b = 1 releases sda; waits out slave stretching
    task automatic bit_io(input logic b, output logic s);
        sda_low_o = !b;
        #QTR;
        scl_low_o = 1'b0;
        wait (scl_i === 1'b1);
        #QTR;
        s = sda_i;
        #QTR;
        scl_low_o = 1'b1;
        #QTR;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_n,
                        output logic [7:0] rx, output logic ack_seen_n);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack_n, ack_seen_n);
    endtask
    // start and stop made here only
    task automatic start;
        sda_low_o = 1'b0;
        scl_low_o = 1'b0;
        wait (scl_i === 1'b1);
        #QTR;
        sda_low_o = 1'b1;
        #QTR;
        scl_low_o = 1'b1;
        #QTR;
    endtask
    task automatic stop;
        sda_low_o = 1'b1;
        #QTR;
        scl_low_o = 1'b0;
        wait (scl_i === 1'b1);
        #QTR;
        sda_low_o = 1'b0;
        #QTR;
    endtask
endmodule
`default_nettype wire

// ---- testbench/isl_props.sv ----
// port-level assertion checker for the two-wire slave interface
`timescale 1ns/1ps
`default_nettype none
module isl_props
    import isl_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins and interrupt
    input wire logic        port_a_bit_six_o,
    input wire logic        port_a_bit_seven_o,
    input wire logic        port_a_bit_six_oe_o,
    input wire logic        port_a_bit_seven_oe_o,
    input wire logic        stack_not_full_i,
    input wire logic        irq_req_o,
    input wire logic [7:0]  irq_vector_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_take(logic [7:0] idx);
        s_req ##0 wb_adr_i[9:2] == idx;
    endsequence

    property p_ack_next;
        s_req |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ctl_zero;
        s_take(IDX_CONTROL) ##0 !wb_we_i |=> wb_dat_o[6:5] == 2'h0 && wb_dat_o[2:0] == 3'h0;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control pad bits");
    property p_sts_zero;
        s_take(IDX_STATUS) ##0 !wb_we_i |=> wb_dat_o[4:3] == 2'h0 && !wb_dat_o[1];
    endproperty
    a_sts_zero: assert property (p_sts_zero) else $error("status pad bits");
    property p_adr_bit0;
        s_take(IDX_OWN_ADDR) ##0 !wb_we_i |=> !wb_dat_o[0] && wb_dat_o[31:8] == 24'h0;
    endproperty
    a_adr_bit0: assert property (p_adr_bit0) else $error("address bit0");
    // release may lag the write by the enable and output registers
    property p_disable;
        s_take(IDX_CONTROL) ##0 (wb_we_i && !wb_dat_i[CTL_EN_BIT])
            |-> ##[1:3] !port_a_bit_six_oe_o && !port_a_bit_seven_oe_o;
    endproperty
    a_disable: assert property (p_disable) else $error("lines held");
    property p_scl_hold;
        port_a_bit_six_oe_o && !(wb_cyc_i && wb_stb_i && !wb_ack_o
            && (wb_adr_i[9:2] == IDX_DATA || wb_adr_i[9:2] == IDX_CONTROL))
            |=> port_a_bit_six_oe_o;
    endproperty
    a_scl_hold: assert property (p_scl_hold) else $error("clock let go");
    // open drain: serial pins may only ever pull low
    property p_od_low;
        port_a_bit_six_o == 1'b0 && port_a_bit_seven_o == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("pin driven high");
    property p_irq_gate;
        irq_req_o |-> stack_not_full_i;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq stack");
    property p_vector;
        irq_vector_o == IRQ_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("vector");
    property p_irq_clear;
        s_take(IDX_IRQ_CTRL) ##0 (wb_we_i && !wb_dat_i[IRQ_FLAG_BIT]) |=> !irq_req_o;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept");
endmodule
`default_nettype wire

// ---- testbench/tb_i2c_slave_interface.sv ----
// self-checking bench for the two-wire slave interface
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_interface;
    import isl_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  gpin;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        nfull = 1'b1;
    logic        irq;
    logic        scl_oe;
    logic        sda_oe;
    logic        m_scl;
    logic        m_sda;
    logic [7:0]  rd;
    logic [7:0]  rx;
    logic        an;
    int          n_errors = 0;
    int          checks_done = 0;
    // open drain with pull-up
    wire logic scl = !(scl_oe | m_scl);
    wire logic sda = !(sda_oe | m_sda);

    always #20 clk = ~clk;

    isl_i2c_slave_interface isl_i2c_slave_interface_i (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .port_a_bit_six_i(scl), .port_a_bit_six_o(), .port_a_bit_six_oe_o(scl_oe),
        .port_a_bit_seven_i(sda), .port_a_bit_seven_o(), .port_a_bit_seven_oe_o(sda_oe),
        .gpio_out_i(2'h0), .gpio_oe_i(2'h0), .gpio_in_o(gpin),
        .stack_not_full_i(nfull), .irq_req_o(irq), .irq_vector_o()
    );
    isl_master_model isl_master_model_i (
        .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda)
    );

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {22'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checks_done++;
        if ((got & m) !== (exp & m))
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
        wb(1'b0, idx, 8'h00);
        chk(rd, exp, m);
    endtask
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_CONTROL, 8'h00, 8'hFF);
        wb(1'b1, IDX_CONTROL, 8'hFF);
        rdc(IDX_CONTROL, 8'h98, 8'hFF);
        wb(1'b1, IDX_STATUS, 8'hFF);
        rdc(IDX_STATUS, 8'h00, 8'hFF);
        wb(1'b1, IDX_OWN_ADDR, 8'hA5);
        rdc(IDX_OWN_ADDR, 8'hA4, 8'hFF);
        rdc(8'h30, 8'h00, 8'hFF);
        chk({6'h0, gpin}, 8'h03, 8'hFF);
        wb(1'b1, IDX_CONTROL, 8'h80);
        wb(1'b1, IDX_IRQ_CTRL, 8'h01);
        // master writes two bytes
        isl_master_model_i.start();
        isl_master_model_i.xfer(8'hA4, 1'b1, rx, an);
        chk({7'h0, an}, 8'h00, 8'hFF);
        settle();
        chk({7'h0, irq}, 8'h01, 8'hFF);
        chk({6'h0, gpin}, 8'h02, 8'hFF);
        nfull <= 1'b0;
        settle();
        chk({7'h0, irq}, 8'h00, 8'hFF);
        nfull <= 1'b1;
        rdc(IDX_STATUS, 8'h60, 8'h7F);
        wb(1'b1, IDX_CONTROL, 8'h80);
        rdc(IDX_STATUS, 8'h20, 8'h7F);
        wb(1'b1, IDX_IRQ_CTRL, 8'h01);
        chk({7'h0, irq}, 8'h00, 8'hFF);
        fork
            isl_master_model_i.xfer(8'hC3, 1'b1, rx, an);
            wb(1'b0, IDX_DATA, 8'h00);
        join
        chk({7'h0, an}, 8'h00, 8'hFF);
        settle();
        chk({7'h0, irq}, 8'h01, 8'hFF);
        rdc(IDX_STATUS, 8'hA0, 8'hFE);
        wb(1'b1, IDX_CONTROL, 8'h88);
        wb(1'b1, IDX_IRQ_CTRL, 8'h01);
        rdc(IDX_DATA, 8'hC3, 8'hFF);
        isl_master_model_i.xfer(8'h3C, 1'b1, rx, an);
        chk({7'h0, an}, 8'h01, 8'hFF);
        settle();
        rdc(IDX_DATA, 8'h3C, 8'hFF);
        isl_master_model_i.stop();
        settle();
        rdc(IDX_STATUS, 8'h00, 8'h20);
        // master reads two bytes, nack on the last
        wb(1'b1, IDX_CONTROL, 8'h80);
        isl_master_model_i.start();
        isl_master_model_i.xfer(8'hA5, 1'b1, rx, an);
        settle();
        rdc(IDX_STATUS, 8'h64, 8'h7F);
        wb(1'b1, IDX_CONTROL, 8'h90);
        wb(1'b1, IDX_IRQ_CTRL, 8'h01);
        fork
            isl_master_model_i.xfer(8'hFF, 1'b0, rx, an);
            wb(1'b1, IDX_DATA, 8'h96);
        join
        chk(rx, 8'h96, 8'hFF);
        settle();
        rdc(IDX_STATUS, 8'hA4, 8'hFF);
        fork
            isl_master_model_i.xfer(8'hFF, 1'b1, rx, an);
            wb(1'b1, IDX_DATA, 8'h5A);
        join
        chk(rx, 8'h5A, 8'hFF);
        settle();
        rdc(IDX_STATUS, 8'hA5, 8'hFF);
        wb(1'b1, IDX_CONTROL, 8'h80);
        wb(1'b0, IDX_DATA, 8'h00);
        settle();
        chk({7'h0, sda_oe}, 8'h00, 8'hFF);
        isl_master_model_i.stop();
        // other address, then disabled
        isl_master_model_i.start();
        isl_master_model_i.xfer(8'h22, 1'b1, rx, an);
        chk({7'h0, an}, 8'h01, 8'hFF);
        isl_master_model_i.stop();
        wb(1'b1, IDX_CONTROL, 8'h00);
        isl_master_model_i.start();
        isl_master_model_i.xfer(8'hA4, 1'b1, rx, an);
        chk({7'h0, an}, 8'h01, 8'hFF);
        isl_master_model_i.stop();
        wrap_up();
    end
endmodule

bind isl_i2c_slave_interface isl_props isl_props_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_a_bit_six_o(port_a_bit_six_o),
    .port_a_bit_seven_o(port_a_bit_seven_o), .port_a_bit_six_oe_o(port_a_bit_six_oe_o),
    .port_a_bit_seven_oe_o(port_a_bit_seven_oe_o), .stack_not_full_i(stack_not_full_i),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o)
);
`default_nettype wire
